// [logic/ptc_capture.sv]
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
// Pre/post trigger capture sequencer with APB registers
module ptc_capture
  import ptc_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 10,
  parameter int PW = 32
)(
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  // APB slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // Capture path
  input  wire logic [DW-1:0] sample_data_i,
  input  wire logic          trigger_i,
  output logic      [DW-1:0] drain_data_o,
  output logic               drain_valid_o,
  // Host side
  output logic               fifo_zero_dma_request_o,
  output logic               advanced_event_irq_zero_o
);

  ptc_ctrl_t       ctrl_reg;
  logic [2:0]      irq_stat_reg;
  logic [2:0]      irq_mask_reg;
  logic [PW-1:0]   period_reg [0:3];
  logic            triggered_reg;
  logic            trig_d_reg;
  logic            rd_ready_reg;
  logic            host_pop_reg;
  logic            drain_pop_reg;
  logic [3:0]      master_en;
  logic [3:0]      start_ev;
  logic [3:0]      stop_ev;
  logic [3:0]      tick;
  logic [3:0]      running;
  logic [PW-1:0]   period_eff [0:3];
  logic            start_pulse;
  logic            trig_pulse;
  logic            setup;
  logic            wr_done;
  logic            rd_done;
  logic            host_pop;
  logic            drain_pop;
  logic            fifo_wr;
  logic            fifo_rd;
  logic [DW-1:0]   fifo_rdata;
  logic [AW:0]     level;
  logic            full;
  logic            empty;
  logic [2:0]      irq_ev;
  logic            mapped;
  logic [31:0]     rd_mux;
  ptc_status_t     status;

  // Bus phases; requests complete on the edge that sees pready high
  always_comb
  begin
    setup   = psel_i && !penable_i;
    wr_done = psel_i && penable_i && pready_o && pwrite_i;
    rd_done = psel_i && penable_i && pready_o && !pwrite_i;
    mapped  = (paddr_i[1:0] == 2'b00) && (paddr_i <= PTC_FIFO_LEVEL_OFS);
    start_pulse = wr_done && (paddr_i == PTC_CTRL_OFS) && pwdata_i[0];
  end

  // Trigger is taken once per run, only while sampling
  always_comb
    trig_pulse = trigger_i && !trig_d_reg && running[PTC_CLK_SAMPLE]
                 && !triggered_reg;

  // Wiring of the four clocks into the capture chain
  always_comb
  begin
    master_en = {tick[PTC_CLK_SAMPLE], 1'b1, tick[PTC_CLK_SAMPLE], 1'b1};
    start_ev  = {trig_pulse, tick[PTC_CLK_PRE], start_pulse,
                 start_pulse};
    stop_ev   = {1'b0, trig_pulse, 1'b0, tick[PTC_CLK_POST]};
    period_eff[0] = period_reg[0];
    period_eff[1] = period_reg[1];
    period_eff[2] = period_reg[0];
    period_eff[3] = period_reg[3];
  end

  // One counter per programmable clock
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_clk
      ptc_prog_clk #(.W(PW)) u_clk (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .master_en_i (master_en[gi]),
        .start_i     (start_ev[gi]),
        .stop_i      (stop_ev[gi]),
        .oneshot_i   (PTC_ONESHOT[gi]),
        .period_i    (period_eff[gi]),
        .tick_o      (tick[gi]),
        .running_o   (running[gi])
      );
    end
  endgenerate

  // FIFO traffic; output clock chosen by the host-output control bit
  always_comb
  begin
    fifo_wr   = tick[PTC_CLK_SAMPLE] && !full;
    drain_pop = tick[PTC_CLK_DRAIN] && !ctrl_reg.host_out && !empty;
    host_pop  = setup && !pwrite_i && (paddr_i == PTC_FIFO_DATA_OFS)
                && ctrl_reg.host_out && !empty;
    fifo_rd   = drain_pop || host_pop;
  end

  ptc_fifo_mem #(.W(DW), .AW(AW)) u_fifo (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (fifo_wr),
    .wdata_i    (sample_data_i),
    .rd_i       (fifo_rd),
    .rdata_o    (fifo_rdata),
    .level_o    (level),
    .full_o     (full),
    .empty_o    (empty)
  );

  // Control and configuration writes; start is a self-clearing pulse
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_reg     <= '0;
      irq_mask_reg <= PTC_IRQ_MASK_RST;
      for (int i = 0; i < 4; i++)
        period_reg[i] <= PW'(PTC_PERIOD_RST);
    end
    else if (wr_done)
    begin
      if (paddr_i == PTC_CTRL_OFS)
        ctrl_reg <= {25'h0, pwdata_i[6:3], 1'b0, pwdata_i[1], 1'b0};
      if (paddr_i == PTC_IRQ_MASK_OFS)
        irq_mask_reg <= pwdata_i[2:0];
      for (int i = 0; i < 4; i++)
        if (paddr_i == PTC_PERIOD0_OFS + 8'(4 * i))
          period_reg[i] <= pwdata_i[PW-1:0];
    end
  end

  // Trigger history; cleared by a new start
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      trig_d_reg    <= 1'b0;
      triggered_reg <= 1'b0;
    end
    else
    begin
      trig_d_reg <= trigger_i;
      if (trig_pulse)
        triggered_reg <= 1'b1;
      else if (start_pulse)
        triggered_reg <= 1'b0;
    end
  end

  // Sticky events; a new event wins over the clear-on-read
  always_comb
  begin
    irq_ev = '0;
    irq_ev[PTC_IRQ_TRIG] = trig_pulse;
    irq_ev[PTC_IRQ_DONE] = tick[PTC_CLK_POST];
    irq_ev[PTC_IRQ_OVF]  = tick[PTC_CLK_SAMPLE] && full;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      irq_stat_reg <= '0;
    else if (rd_done && paddr_i == PTC_IRQ_STAT_OFS)
      irq_stat_reg <= irq_ev;
    else
      irq_stat_reg <= irq_stat_reg | irq_ev;
  end

  // Source mask, module enable and bridge enable all gate the line
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      advanced_event_irq_zero_o <= 1'b0;
    else
      advanced_event_irq_zero_o <= ctrl_reg.bridge_en &&
        |(irq_stat_reg & irq_mask_reg & ctrl_reg.module_en);
  end

  // Read-ready with hysteresis keeps DMA bursts at least 128 words
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      rd_ready_reg <= 1'b0;
    else if (level >= (AW+1)'(PTC_RDREQ_ON))
      rd_ready_reg <= 1'b1;
    else if (level < (AW+1)'(PTC_RDREQ_OFF))
      rd_ready_reg <= 1'b0;
  end

  // DMA channel zero request mirrors read-ready
  always_comb
    fifo_zero_dma_request_o = rd_ready_reg;

  // Drained words go to the peripheral output two edges after the pop
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      drain_pop_reg <= 1'b0;
      drain_valid_o <= 1'b0;
      drain_data_o  <= '0;
    end
    else
    begin
      drain_pop_reg <= drain_pop;
      drain_valid_o <= drain_pop_reg;
      if (drain_pop_reg)
        drain_data_o <= fifo_rdata;
    end
  end

  // Status view of the sequencer
  always_comb
  begin
    status           = '0;
    status.running   = running;
    status.triggered = triggered_reg;
    status.rd_ready  = rd_ready_reg;
    status.empty     = empty;
    status.full      = full;
  end

  // Read data selection; a pop from an empty FIFO reads as zero
  always_comb
  begin
    rd_mux = '0;
    unique case (paddr_i)
      PTC_CTRL_OFS:       rd_mux = ctrl_reg;
      PTC_STATUS_OFS:     rd_mux = status;
      PTC_IRQ_STAT_OFS:   rd_mux = {29'h0, irq_stat_reg | irq_ev};
      PTC_IRQ_MASK_OFS:   rd_mux = {29'h0, irq_mask_reg};
      PTC_FIFO_DATA_OFS:  rd_mux = host_pop_reg ? 32'(fifo_rdata) : '0;
      PTC_FIFO_LEVEL_OFS: rd_mux = 32'(level);
      default:
      begin
        for (int i = 0; i < 4; i++)
          if (paddr_i == PTC_PERIOD0_OFS + 8'(4 * i))
            rd_mux = 32'(period_reg[i]);
      end
    endcase
  end

  // One wait state lets the FIFO register its read word
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      pready_o     <= 1'b0;
      prdata_o     <= '0;
      pslverr_o    <= 1'b0;
      host_pop_reg <= 1'b0;
    end
    else
    begin
      if (setup)
        host_pop_reg <= host_pop;
      if (pready_o)
      begin
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
      end
      else if (psel_i && penable_i)
      begin
        pready_o  <= 1'b1;
        pslverr_o <= !mapped;
        prdata_o  <= pwrite_i ? '0 : rd_mux;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_trig_taken;
    trig_pulse ##1 !running[PTC_CLK_DRAIN];
  endsequence

  a_trig_stops_drain: assert property (trig_pulse |-> s_trig_taken)
    else $error("drain clock still running after trigger");
  a_trig_starts_post: assert property (
    trig_pulse |=> running[PTC_CLK_POST])
    else $error("post clock not started by trigger");
  a_post_stops_sample: assert property (
    tick[PTC_CLK_POST] |=> !running[PTC_CLK_SAMPLE] [*2])
    else $error("sample clock still running after post expiry");
  a_pre_starts_drain: assert property (
    tick[PTC_CLK_PRE] && !trig_pulse && !triggered_reg
    |=> running[PTC_CLK_DRAIN])
    else $error("pre-fill expiry did not start drain clock");
  a_sample_writes_word: assert property (
    tick[PTC_CLK_SAMPLE] && !full && !fifo_rd
    |=> level == $past(level) + 1'b1)
    else $error("sample tick did not add one word");
  a_drain_removes_word: assert property (
    tick[PTC_CLK_DRAIN] && !ctrl_reg.host_out && !empty
    |=> level + 1'b1 == $past(level) + $past(fifo_wr))
    else $error("drain tick did not remove one word");
  a_host_mode_holds: assert property (
    ctrl_reg.host_out && !host_pop && !fifo_wr |=> level == $past(level))
    else $error("FIFO level moved without host read in host mode");
  a_rdreq_on_level: assert property (
    level >= (AW+1)'(PTC_RDREQ_ON) |=> fifo_zero_dma_request_o)
    else $error("read request missing at high level");
  a_rdreq_off_level: assert property (
    level < (AW+1)'(PTC_RDREQ_OFF) |=> !fifo_zero_dma_request_o)
    else $error("read request held at low level");
  a_irq_bridge_gate: assert property (
    !ctrl_reg.bridge_en |=> !advanced_event_irq_zero_o)
    else $error("interrupt raised with bridge level disabled");
  a_expiry_one_cycle: assert property (
    tick[PTC_CLK_PRE] |=> !tick[PTC_CLK_PRE])
    else $error("one-shot expiry longer than one cycle");

endmodule

// [logic/ptc_pkg.sv]
// Contract
// - An interrupt reaches the host only when enabled at bridge, module and source level.
// - Clock zero is the sample clock; each tick writes one word, it starts on start and stops on clock three expiry.
// - Clock one is a one-shot counting N sample ticks from sampling start; its expiry starts clock two.
// - Clock two runs at the sample clock period and master, and each tick removes one FIFO word.
// - The trigger event stops clock two so the FIFO starts to accumulate.
// - The trigger event starts clock three, a one-shot counting M sample ticks.
// - Clock three expiry stops the sample clock and ends collection.
// - The FIFO output clock is selectable: clock two before the trigger, host reads after.
// - Read-ready asserts at 256 words or more and deasserts below 128 words.
// - FIFO zero is served by DMA channel zero.
package ptc_pkg;

  // Register byte offsets
  localparam logic [7:0] PTC_CTRL_OFS       = 8'h00;
  localparam logic [7:0] PTC_STATUS_OFS     = 8'h04;
  localparam logic [7:0] PTC_IRQ_STAT_OFS   = 8'h08;
  localparam logic [7:0] PTC_IRQ_MASK_OFS   = 8'h0c;
  localparam logic [7:0] PTC_PERIOD0_OFS    = 8'h10;
  localparam logic [7:0] PTC_FIFO_DATA_OFS  = 8'h20;
  localparam logic [7:0] PTC_FIFO_LEVEL_OFS = 8'h24;

  // Reset values
  localparam logic [31:0] PTC_PERIOD_RST    = 32'h0000_0001;
  localparam logic [2:0]  PTC_IRQ_MASK_RST  = 3'h0;

  // Read-ready hysteresis thresholds in words
  localparam int PTC_RDREQ_ON  = 256;
  localparam int PTC_RDREQ_OFF = 128;

  // Interrupt source positions, one module per source
  localparam int PTC_IRQ_TRIG = 0;
  localparam int PTC_IRQ_DONE = 1;
  localparam int PTC_IRQ_OVF  = 2;

  // Programmable clock roles
  localparam int PTC_CLK_SAMPLE = 0;
  localparam int PTC_CLK_PRE    = 1;
  localparam int PTC_CLK_DRAIN  = 2;
  localparam int PTC_CLK_POST   = 3;
  localparam logic [3:0] PTC_ONESHOT = 4'ha;

  // Control register, bit 31 downward
  typedef struct packed {
    logic [24:0] rsvd;
    logic [2:0]  module_en;
    logic        bridge_en;
    logic        rsvd1;
    logic        host_out;
    logic        start;
  } ptc_ctrl_t;

  // Status register, bit 31 downward
  typedef struct packed {
    logic [23:0] rsvd;
    logic        full;
    logic        empty;
    logic        rd_ready;
    logic        triggered;
    logic [3:0]  running;
  } ptc_status_t;

endpackage

// [logic/ptc_fifo_mem.sv]
`timescale 1ns/10ps
// Synchronous FIFO; read data comes from a register one edge after pop
module ptc_fifo_mem
  import ptc_pkg::*;
#(
  parameter int W  = 16,
  parameter int AW = 10
)(
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  // Write side
  input  wire logic          wr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read side
  input  wire logic          rd_i,
  output logic      [W-1:0]  rdata_o,
  // Occupancy
  output logic      [AW:0]   level_o,
  output logic               full_o,
  output logic               empty_o
);

  logic [W-1:0] mem_reg [0:(1<<AW)-1];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;

  // Pointers; callers never push when full or pop when empty
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      if (wr_i)
        wptr_reg <= wptr_reg + 1'b1;
      if (rd_i)
        rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Storage has no reset so it can map to block RAM
  always_ff @(posedge core_clk_i)
  begin
    if (wr_i)
      mem_reg[wptr_reg[AW-1:0]] <= wdata_i;
  end

  // Registered read port
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= mem_reg[rptr_reg[AW-1:0]];
  end

  // Occupancy flags
  always_comb
  begin
    level_o = wptr_reg - rptr_reg;
    full_o  = level_o[AW];
    empty_o = (level_o == '0);
  end

endmodule

// [logic/ptc_prog_clk.sv]
`timescale 1ns/10ps
// Programmable clock: counts master enables, ticks on each period end
module ptc_prog_clk
  import ptc_pkg::*;
#(
  parameter int W = 32
)(
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  // Control
  input  wire logic          master_en_i,
  input  wire logic          start_i,
  input  wire logic          stop_i,
  input  wire logic          oneshot_i,
  input  wire logic [W-1:0]  period_i,
  // Result
  output logic               tick_o,
  output logic               running_o
);

  logic [W-1:0] cnt_reg;
  logic         last;

  // A period of zero behaves as one
  always_comb
    last = (period_i <= W'(1)) || (cnt_reg >= period_i - W'(1));

  // Stop beats start; a start while running is ignored
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg   <= '0;
      running_o <= 1'b0;
      tick_o    <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (stop_i)
        running_o <= 1'b0;
      else if (start_i && !running_o)
      begin
        running_o <= 1'b1;
        cnt_reg   <= '0;
      end
      else if (running_o && master_en_i)
      begin
        if (last)
        begin
          tick_o  <= 1'b1;
          cnt_reg <= '0;
          if (oneshot_i)
            running_o <= 1'b0;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// [verification/ptc_host_bfm.sv]
`timescale 1ns/10ps
// Host side bus model: one APB transfer per go pulse from the bench
module ptc_host_bfm (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Request from the bench
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             done_o,
  output logic [31:0]      rdata_o,
  output logic             err_o,
  // APB master pins
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  // Request held until pready; released address and data lines carry inverted junk so
  // a slave that samples them late sees a wrong value, not a stale one
  always_ff @(posedge core_clk_i)
  begin
    done_o <= 1'b0;
    if (!rstn_i)
    begin
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o  <= 1'b0;
      paddr_o   <= 8'h00;
      pwdata_o  <= 32'h0000_0000;
      rdata_o   <= 32'h0000_0000;
      err_o     <= 1'b0;
    end
    else if (psel_o && penable_o && pready_i)
    begin
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      paddr_o   <= ~paddr_o;
      pwdata_o  <= ~pwdata_o;
      rdata_o   <= prdata_i;
      err_o     <= pslverr_i;
      done_o    <= 1'b1;
    end
    else if (psel_o)
      penable_o <= 1'b1;
    else if (go_i)
    begin
      psel_o   <= 1'b1;
      pwrite_o <= wr_i;
      paddr_o  <= addr_i;
      pwdata_o <= wdata_i;
    end
  end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// Capture sequencer bench: host bus model plus sample and trigger source
module tb_top
  import ptc_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, hd, hq, q, w;
  logic [15:0] sample_data = 16'h0000;
  logic [15:0] drain_data;
  logic [15:0] dprev;
  logic        trigger = 1'b0;
  logic        drain_valid, dma_req, irq, done, herr, rr, trig_seen;
  logic        go = 1'b0;
  logic        hw = 1'b0;
  logic [7:0]  ha = 8'h00;
  int          miscompares, check_count, seed, n, lvl, lvl2, early, late;

  ptc_capture dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sample_data_i(sample_data),
    .trigger_i(trigger), .drain_data_o(drain_data),
    .drain_valid_o(drain_valid), .fifo_zero_dma_request_o(dma_req),
    .advanced_event_irq_zero_o(irq));
  ptc_host_bfm host (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go),
    .wr_i(hw), .addr_i(ha), .wdata_i(hd), .done_o(done), .rdata_o(hq),
    .err_o(herr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  always #5 core_clk_i = ~core_clk_i;

  // Ramp data, so word order in the FIFO can be checked on the way out
  always @(posedge core_clk_i)
    sample_data <= sample_data + 16'h0001;

  // Drain pulses split at the trigger; later ones mean removal went on
  always @(posedge core_clk_i)
    if (drain_valid === 1'b1)
    begin
      // Drained words leave in ramp order, one apart
      if (early + late > 0)
        `CHK(drain_data, dprev + 16'h0001)
      dprev = drain_data;
      if (trig_seen)
        late++;
      else
        early++;
    end

  // Read-ready with hysteresis between the two thresholds
  function automatic logic exp_rr(input logic prev, input int l);
    if (l >= PTC_RDREQ_ON)
      return 1'b1;
    if (l < PTC_RDREQ_OFF)
      return 1'b0;
    return prev;
  endfunction

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge core_clk_i);
    hw <= wr;
    ha <= a;
    hd <= d;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    while (done !== 1'b1 && k < 40)
    begin
      @(negedge core_clk_i);
      k++;
    end
    if (k >= 40)
    begin
      miscompares++;
      $display("[ERR] %0t bus transfer hung", $time);
    end
    r = hq;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles the run needs
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    miscompares++;
    test_done();
  end

  initial
  begin
    seed = 96;
    trig_seen = 1'b0;
    hd = 32'h0000_0000;
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, PTC_CTRL_OFS, 0, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, PTC_IRQ_MASK_OFS, 0, q);
    `CHK(q[2:0], PTC_IRQ_MASK_RST)
    bus(1'b0, PTC_PERIOD0_OFS, 0, q);
    `CHK(q, PTC_PERIOD_RST)
    bus(1'b0, PTC_FIFO_DATA_OFS, 0, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 8'h30, 0, q);
    `CHK(herr, 1'b1)
    $display("test reset and map done");
    // Chain set up fully before sampling starts, random pre-fill count
    n = 8 + ($random(seed) & 31);
    bus(1'b1, PTC_PERIOD0_OFS, 32'h1, q);
    bus(1'b1, PTC_PERIOD0_OFS + 8'h04, n, q);
    bus(1'b1, PTC_PERIOD0_OFS + 8'h0c, 300, q);
    bus(1'b1, PTC_CTRL_OFS, 32'h78, q);
    bus(1'b1, PTC_CTRL_OFS, 32'h79, q);
    bus(1'b0, PTC_STATUS_OFS, 0, q);
    `CHK(q[1:0], 2'b11)
    idle(n + 10 + ($random(seed) & 31));
    bus(1'b0, PTC_FIFO_LEVEL_OFS, 0, q);
    lvl = q;
    bus(1'b0, PTC_FIFO_LEVEL_OFS, 0, q);
    `CHK(q, lvl)
    `CHK(early > 0, 1'b1)
    @(posedge core_clk_i);
    trigger <= 1'b1;
    idle(4);
    trig_seen = 1'b1;
    `CHK(irq, 1'b0)
    bus(1'b0, PTC_STATUS_OFS, 0, q);
    `CHK({q[4], q[3], q[2]}, 3'b110)
    $display("test pre-fill and trigger done");
    bus(1'b1, PTC_IRQ_MASK_OFS, 32'h1, q);
    idle(3);
    `CHK(irq, 1'b1)
    bus(1'b1, PTC_CTRL_OFS, 32'h72, q);
    idle(3);
    `CHK(irq, 1'b0)
    bus(1'b1, PTC_CTRL_OFS, 32'h7a, q);
    idle(3);
    `CHK(irq, 1'b1)
    bus(1'b0, PTC_IRQ_STAT_OFS, 0, q);
    `CHK(q[0], 1'b1)
    idle(3);
    `CHK(irq, 1'b0)
    $display("test interrupt levels done");
    lvl = 0;
    q = 32'h1;
    while (q[0] === 1'b1 && lvl < 200)
    begin
      bus(1'b0, PTC_STATUS_OFS, 0, q);
      lvl++;
    end
    `CHK(late, 0)
    `CHK(q[0], 1'b0)
    bus(1'b0, PTC_FIFO_LEVEL_OFS, 0, q);
    lvl = q;
    idle(20);
    bus(1'b0, PTC_FIFO_LEVEL_OFS, 0, q);
    `CHK(q, lvl)
    `CHK(lvl >= 300 && lvl <= 300 + n + 4, 1'b1)
    `CHK(dma_req, 1'b1)
    bus(1'b0, PTC_IRQ_STAT_OFS, 0, q);
    `CHK(q[1], 1'b1)
    $display("test post-trigger count done");
    // Host drains by reads; request follows the hysteresis on the way
    rr = 1'b1;
    lvl2 = 0;
    while (lvl > 0 && lvl2 < 1100)
    begin
      bus(1'b0, PTC_FIFO_DATA_OFS, 0, w);
      if (lvl2 > 0)
        `CHK(w[15:0], q[15:0] + 16'h0001)
      q = w;
      bus(1'b0, PTC_FIFO_LEVEL_OFS, 0, w);
      lvl = w;
      rr = exp_rr(rr, lvl);
      idle(2);
      `CHK(dma_req, rr)
      lvl2++;
    end
    bus(1'b0, PTC_FIFO_DATA_OFS, 0, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, PTC_STATUS_OFS, 0, q);
    `CHK(q[6], 1'b1)
    $display("test host drain done");
    test_done();
  end
endmodule
